// [common/sgc_pkg.sv]
// Summary of operation
// - buffer-share 1 lets all ports share the pool; 0 caps each port at one fifth; resets 1.
// - conformance drop mode set drops type/length 0x8808 or DA 01-80-C2-00-00-01.
// - conformance drop mode clear (reset) drops only frames classified as flow control.
// - link-change aging on: while aging is enabled, a link loss starts one fast pass, then aging resumes at the period fast-age selects.
// - any port losing its link ages out every learned address.
// - pass-all set forwards every frame including errored ones; debug use with sniffing.
// - transmit flow-control disable 0 follows negotiation; 1 never enables pause transmission.
// - receive flow-control disable 0 follows negotiation; 1 ignores received pause frames.
// - both flow-control disables reset from one strap, yet are written independently.
// - length check set drops frames with type/length below 1500 not matching real length.
// - aging enable turns table aging on or off; resets from a strap, pulled up enables.
// - fast-age set ages on an 800 us period instead of normal; resets 0.
// - aggressive backoff set gives half-duplex ports non-standard backoff; resets from strap.
`default_nettype none
package sgc_pkg;
    // ****************************************************
    // clock and timing
    // ****************************************************
    localparam int CLK_MHZ = 250;
    localparam int US_PER_S = 1000000;
    localparam int US_CYC = CLK_MHZ;
    localparam int AGE_NORMAL_S = 300;
    localparam int AGE_FAST_US = 800;
    localparam int AGE_NORMAL_US = AGE_NORMAL_S * US_PER_S;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // ****************************************************
    // register map (index, byte address = index * 4)
    // ****************************************************
    localparam logic [5:0] REG_GC0_IDX = 6'h02;
    localparam logic [5:0] REG_GC1_IDX = 6'h03;
    localparam logic [5:0] REG_STAT_IDX = 6'h06;
    localparam logic [7:0] ADDR_GC0 = {REG_GC0_IDX, 2'h0};
    localparam logic [7:0] ADDR_GC1 = {REG_GC1_IDX, 2'h0};
    localparam logic [7:0] ADDR_STAT = {REG_STAT_IDX, 2'h0};
    localparam int GC0_BUF_SHARE = 2;
    localparam int GC0_CONF_DROP = 1;
    localparam int GC0_LINK_AGE = 0;
    localparam int GC1_PASS_ALL = 7;
    localparam int GC1_TXFC_DIS = 5;
    localparam int GC1_RXFC_DIS = 4;
    localparam int GC1_LEN_CHK = 3;
    localparam int GC1_AGE_EN = 2;
    localparam int GC1_FAST_AGE = 1;
    localparam int GC1_AGGR_BO = 0;
    localparam int STAT_LINK_PASS = 0;
    localparam int STAT_AGE_ON = 1;
    localparam logic [7:0] GC0_RESET = 8'h4C;
    localparam logic [7:0] GC1_RESET = 8'h00;
    // ****************************************************
    // frame classification, port buffer pool and bus states
    // ****************************************************
    localparam logic [15:0] FC_TYPE = 16'h8808;
    localparam logic [47:0] FC_DA = 48'h0180C2000001;
    localparam logic [15:0] LEN_FIELD_MAX = 16'h05DC;
    localparam int NUM_PORTS = 5;
    localparam logic [9:0] POOL_BUFS = 10'h200;
    localparam logic [9:0] SHARE_DIV = 10'h005;
    localparam logic [9:0] PORT_CAP = POOL_BUFS / SHARE_DIV;
    typedef enum logic [2:0] {
        ST_STRAP = 3'h1,
        ST_IDLE = 3'h2,
        ST_ACK = 3'h4
    } sgc_bus_e;
endpackage
`default_nettype wire

// [common/sgc_age_if.sv]
`default_nettype none
interface sgc_age_if;
    logic enable;
    logic fast;
    logic link_start;
    logic pass;
    logic link_busy;
    modport ctl (output enable, output fast, output link_start, input pass, input link_busy);
    modport tmr (input enable, input fast, input link_start, output pass, output link_busy);
endinterface
`default_nettype wire

// [hdl/sgc_age_timer.sv]
`default_nettype none
module sgc_age_timer
    import sgc_pkg::*;
#(
    parameter int NORMAL_US = AGE_NORMAL_US,
    parameter int FAST_US = AGE_FAST_US
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // control
    sgc_age_if.tmr age
);
    // ****************************************************
    // microsecond prescaler and period counter
    // ****************************************************
    logic [7:0] us_cnt, next_us_cnt;
    logic [31:0] per_cnt, next_per_cnt;
    logic link_mode, next_link_mode;
    logic pass, next_pass;
    logic [31:0] limit;

    always_comb begin
        limit = (age.fast || link_mode) ? 32'(FAST_US) : 32'(NORMAL_US);
        next_us_cnt = us_cnt;
        next_per_cnt = per_cnt;
        next_link_mode = link_mode;
        next_pass = 1'b0;
        if (age.link_start) begin
            // restart so the link pass gets a full fast period
            next_us_cnt = 8'h00;
            next_per_cnt = 32'h0;
            next_link_mode = 1'b1;
        end else if (!age.enable) begin
            next_us_cnt = 8'h00;
            next_per_cnt = 32'h0;
            next_link_mode = 1'b0;
        end else if (us_cnt == 8'(US_CYC - 1)) begin
            next_us_cnt = 8'h00;
            if (per_cnt >= limit - 32'h1) begin
                next_per_cnt = 32'h0;
                next_pass = 1'b1;
                next_link_mode = 1'b0;
            end else begin
                next_per_cnt = per_cnt + 32'h1;
            end
        end else begin
            next_us_cnt = us_cnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            us_cnt <= 8'h00;
            per_cnt <= 32'h0;
            link_mode <= 1'b0;
            pass <= 1'b0;
        end else begin
            us_cnt <= next_us_cnt;
            per_cnt <= next_per_cnt;
            link_mode <= next_link_mode;
            pass <= next_pass;
        end
    end

    assign age.pass = pass;
    assign age.link_busy = link_mode;
endmodule
`default_nettype wire

// [hdl/sgc_top.sv]
// Local design decision: the Avalon-MM slave port.
`default_nettype none
module sgc_top
    import sgc_pkg::*;
#(
    parameter int NORMAL_US = AGE_NORMAL_US,
    parameter int FAST_US = AGE_FAST_US
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // strap pins
    input wire logic flow_ctrl_strap_pin,
    input wire logic backoff_strap_pin,
    input wire logic aging_strap_pin,
    // port link and negotiation results
    input wire logic [NUM_PORTS-1:0] port_link,
    input wire logic an_pause_tx,
    input wire logic an_pause_rx,
    // received frame summary
    input wire logic frm_valid,
    input wire logic [15:0] frm_type_len,
    input wire logic [47:0] frm_da,
    input wire logic frm_is_flow_ctrl,
    input wire logic frm_err,
    input wire logic [15:0] frm_len,
    // frame verdict
    output logic frm_done,
    output logic frm_drop,
    // switch controls
    output logic [9:0] port_buf_cap,
    output logic pause_tx_en,
    output logic pause_rx_en,
    output logic aggr_backoff,
    output logic age_pass,
    output logic age_flush_all
);
    // ****************************************************
    // strap synchronisers
    // ****************************************************
    logic [2:0] strap_meta, strap_sync;
    logic [1:0] strap_cnt, next_strap_cnt;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            strap_meta <= 3'h0;
            strap_sync <= 3'h0;
        end else begin
            strap_meta <= {aging_strap_pin, backoff_strap_pin, flow_ctrl_strap_pin};
            strap_sync <= strap_meta;
        end
    end

    // ****************************************************
    // register bank and bus slave
    // ****************************************************
    sgc_bus_e state, next_state;
    logic [7:0] gc0, next_gc0;
    logic [7:0] gc1, next_gc1;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic [7:0] stat;
    sgc_age_if age ();

    assign stat = {6'h00, (gc1[GC1_AGE_EN] | age.link_busy), age.link_busy};

    always_comb begin
        next_state = state;
        next_gc0 = gc0;
        next_gc1 = gc1;
        next_readdata = avs_readdata;
        next_waitrequest = 1'b1;
        next_strap_cnt = strap_cnt;
        unique case (state)
            ST_STRAP: begin
                // hold off the bus until the synchronised straps are valid
                if (strap_cnt == STRAP_SETTLE) begin
                    next_gc1[GC1_TXFC_DIS] = strap_sync[0];
                    next_gc1[GC1_RXFC_DIS] = strap_sync[0];
                    next_gc1[GC1_AGGR_BO] = strap_sync[1];
                    next_gc1[GC1_AGE_EN] = strap_sync[2];
                    next_state = ST_IDLE;
                end else begin
                    next_strap_cnt = strap_cnt + 2'h1;
                end
            end
            ST_IDLE: begin
                if (avs_read || avs_write) begin
                    next_state = ST_ACK;
                    next_waitrequest = 1'b0;
                    if (avs_address == ADDR_GC0) begin
                        next_readdata = {24'h0, gc0};
                    end else if (avs_address == ADDR_GC1) begin
                        next_readdata = {24'h0, gc1};
                    end else if (avs_address == ADDR_STAT) begin
                        next_readdata = {24'h0, stat};
                    end else begin
                        next_readdata = 32'h0;
                    end
                end
            end
            ST_ACK: begin
                next_state = ST_IDLE;
                // write lands on the edge where the master sees waitrequest low
                if (avs_write && avs_byteenable[0]) begin
                    if (avs_address == ADDR_GC0) begin
                        next_gc0 = avs_writedata[7:0];
                    end
                    if (avs_address == ADDR_GC1) begin
                        next_gc1 = avs_writedata[7:0];
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_STRAP;
            gc0 <= GC0_RESET;
            gc1 <= GC1_RESET;
            avs_readdata <= 32'h0;
            avs_waitrequest <= 1'b1;
            strap_cnt <= 2'h0;
        end else begin
            state <= next_state;
            gc0 <= next_gc0;
            gc1 <= next_gc1;
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
            strap_cnt <= next_strap_cnt;
        end
    end

    // ****************************************************
    // frame filter
    // ****************************************************
    logic next_frm_done, next_frm_drop;
    logic conf_hit, len_bad;

    always_comb begin
        conf_hit = (frm_type_len == FC_TYPE) || (frm_da == FC_DA);
        len_bad = (frm_type_len < LEN_FIELD_MAX) && (frm_len != frm_type_len);
        next_frm_done = frm_valid;
        next_frm_drop = 1'b0;
        if (frm_valid && !gc1[GC1_PASS_ALL]) begin
            // pass-all forwards everything, so it masks every drop below
            next_frm_drop = frm_err;
            if (gc0[GC0_CONF_DROP] ? conf_hit : frm_is_flow_ctrl) begin
                next_frm_drop = 1'b1;
            end
            if (gc1[GC1_LEN_CHK] && len_bad) begin
                next_frm_drop = 1'b1;
            end
        end
    end

    // ****************************************************
    // aging control and static controls
    // ****************************************************
    logic [NUM_PORTS-1:0] link_prev;
    logic link_lost;
    logic [9:0] next_port_buf_cap;
    logic next_pause_tx_en, next_pause_rx_en, next_aggr_backoff;

    always_comb begin
        link_lost = |(link_prev & ~port_link);
        age.enable = gc1[GC1_AGE_EN];
        age.fast = gc1[GC1_FAST_AGE];
        age.link_start = link_lost && gc0[GC0_LINK_AGE];
        next_port_buf_cap = gc0[GC0_BUF_SHARE] ? POOL_BUFS : PORT_CAP;
        next_pause_tx_en = an_pause_tx && !gc1[GC1_TXFC_DIS];
        next_pause_rx_en = an_pause_rx && !gc1[GC1_RXFC_DIS];
        next_aggr_backoff = gc1[GC1_AGGR_BO];
    end

    sgc_age_timer #(
        .NORMAL_US(NORMAL_US),
        .FAST_US(FAST_US)
    ) u_age (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .age(age.tmr)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            frm_done <= 1'b0;
            frm_drop <= 1'b0;
            link_prev <= '0;
            port_buf_cap <= POOL_BUFS;
            pause_tx_en <= 1'b0;
            pause_rx_en <= 1'b0;
            aggr_backoff <= 1'b0;
            age_pass <= 1'b0;
            age_flush_all <= 1'b0;
        end else begin
            frm_done <= next_frm_done;
            frm_drop <= next_frm_drop;
            link_prev <= port_link;
            port_buf_cap <= next_port_buf_cap;
            pause_tx_en <= next_pause_tx_en;
            pause_rx_en <= next_pause_rx_en;
            aggr_backoff <= next_aggr_backoff;
            age_pass <= age.pass;
            age_flush_all <= link_lost;
        end
    end
endmodule
`default_nettype wire

// [verif/sgc_top_monitor.sv]
`default_nettype none
module sgc_top_monitor
    import sgc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // link, negotiation and frames
    input wire logic [NUM_PORTS-1:0] port_link,
    input wire logic an_pause_tx,
    input wire logic an_pause_rx,
    input wire logic frm_valid,
    input wire logic frm_done,
    // switch controls
    input wire logic [9:0] port_buf_cap,
    input wire logic pause_tx_en,
    input wire logic pause_rx_en,
    input wire logic age_pass,
    input wire logic age_flush_all
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ****
    // checks
    // ****
    property p_done; frm_valid |=> frm_done; endproperty
    a_done: assert property (p_done) else $error("verdict late");
    property p_cause; frm_done |-> $past(frm_valid); endproperty
    a_cause: assert property (p_cause) else $error("verdict without frame");
    property p_cap; port_buf_cap == 10'h200 || port_buf_cap == PORT_CAP; endproperty
    a_cap: assert property (p_cap) else $error("bad buffer cap");
    // the cap only moves one edge after a register write lands
    property p_cap_hold; !$stable(port_buf_cap) |-> $past(avs_write, 2); endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("buffer cap changed without a write");
    property p_tx; pause_tx_en |-> $past(an_pause_tx); endproperty
    a_tx: assert property (p_tx) else $error("tx pause not negotiated");
    property p_rx; pause_rx_en |-> $past(an_pause_rx); endproperty
    a_rx: assert property (p_rx) else $error("rx pause not negotiated");
    property p_flush; |($past(port_link) & ~port_link) |=> age_flush_all; endproperty
    a_flush: assert property (p_flush) else $error("no flush on link loss");
    property p_ws; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_ws: assert property (p_ws) else $error("answer too long");
    // a stalled bus during strap settle still answers in bounded time
    property p_ans; (avs_read || avs_write) && avs_waitrequest |-> ##[0:8] !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("bus hang");
    property p_pass; age_pass |=> !age_pass; endproperty
    a_pass: assert property (p_pass) else $error("aging pulse too long");
endmodule
`default_nettype wire

// [verif/sgc_top_tb.sv]
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin $display("[ERR] %s exp %h got %h", n, e, a); errors++; end end
module sgc_top_tb import sgc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // short periods keep the aging run small
    localparam int FAST = 3;
    localparam int NORM = 20;
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, frm_done, frm_drop, pause_tx_en, pause_rx_en, aggr_backoff, age_pass, age_flush_all;
    logic flow_ctrl_strap_pin = 1'h1;
    logic backoff_strap_pin = 1'h1;
    logic aging_strap_pin = 1'h1;
    logic [NUM_PORTS-1:0] port_link = 5'h1F;
    logic an_pause_tx = 1'h1;
    logic an_pause_rx = 1'h1;
    logic frm_valid = 1'h0;
    logic frm_is_flow_ctrl = 1'h0;
    logic frm_err = 1'h0;
    logic [15:0] frm_type_len = 16'h0, frm_len = 16'h0;
    logic [47:0] frm_da = 48'h0;
    logic [9:0] port_buf_cap;
    int errors = 0, comparisons = 0, cyc = 0, n;
    sgc_top #(.NORMAL_US(NORM), .FAST_US(FAST)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flow_ctrl_strap_pin(flow_ctrl_strap_pin),
        .backoff_strap_pin(backoff_strap_pin), .aging_strap_pin(aging_strap_pin), .port_link(port_link),
        .an_pause_tx(an_pause_tx), .an_pause_rx(an_pause_rx), .frm_valid(frm_valid), .frm_type_len(frm_type_len),
        .frm_da(frm_da), .frm_is_flow_ctrl(frm_is_flow_ctrl), .frm_err(frm_err), .frm_len(frm_len),
        .frm_done(frm_done), .frm_drop(frm_drop), .port_buf_cap(port_buf_cap), .pause_tx_en(pause_tx_en),
        .pause_rx_en(pause_rx_en), .aggr_backoff(aggr_backoff), .age_pass(age_pass), .age_flush_all(age_flush_all));
    initial forever #2 ref_clk = ~ref_clk;
    // ****
    // shared tasks
    // ****
    task automatic complete_run();
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, a, d, 4'hF);
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 8'h00, 4'hF);
        `CHK("readdata", e, rd)
    endtask
    task automatic frm(input logic [15:0] t, input logic [47:0] da, input logic fc, input logic [15:0] ln,
                       input logic er, input logic e);
        @(posedge ref_clk);
        frm_valid <= 1'h1;
        frm_type_len <= t;
        frm_da <= da;
        frm_is_flow_ctrl <= fc;
        frm_len <= ln;
        frm_err <= er;
        @(posedge ref_clk);
        frm_valid <= 1'h0;
        @(posedge ref_clk);
        `CHK("frm_done", 1'h1, frm_done)
        `CHK("frm_drop", e, frm_drop)
    endtask
    task automatic gap(output int c);
        c = 0;
        do begin @(posedge ref_clk); c++; end while (age_pass !== 1'h1);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        rchk(ADDR_GC0, 32'h4C);
        rchk(ADDR_GC1, 32'h35);
        bus(1'h1, ADDR_GC1, 8'hFF, 4'h0);
        rchk(ADDR_GC1, 32'h35);
        rchk(8'h40, 32'h0);
        `CHK("port_buf_cap", 10'h200, port_buf_cap)
        `CHK("pause_tx_en", 1'h0, pause_tx_en)
        `CHK("pause_rx_en", 1'h0, pause_rx_en)
        `CHK("aggr_backoff", 1'h1, aggr_backoff)
    endtask
    task automatic t_flow();
        wr(ADDR_GC1, 8'h14);
        `CHK("pause_tx_en", 1'h1, pause_tx_en)
        `CHK("pause_rx_en", 1'h0, pause_rx_en)
        wr(ADDR_GC1, 8'h24);
        `CHK("pause_tx_en", 1'h0, pause_tx_en)
        `CHK("pause_rx_en", 1'h1, pause_rx_en)
        an_pause_rx <= 1'h0;
        repeat (3) @(posedge ref_clk);
        `CHK("pause_rx_en", 1'h0, pause_rx_en)
        an_pause_rx <= 1'h1;
        wr(ADDR_GC0, 8'h48);
        `CHK("port_buf_cap", PORT_CAP, port_buf_cap)
        wr(ADDR_GC0, 8'h4C);
        `CHK("port_buf_cap", 10'h200, port_buf_cap)
    endtask
    task automatic t_frame();
        wr(ADDR_GC1, 8'h04);
        frm(16'h0800, 48'h0, 1'h1, 16'h0, 1'h0, 1'h1);
        frm(FC_TYPE, FC_DA, 1'h0, 16'h0, 1'h0, 1'h0);
        frm(16'h0800, 48'h0, 1'h0, 16'h0, 1'h1, 1'h1);
        wr(ADDR_GC0, 8'h4E);
        frm(FC_TYPE, 48'h0, 1'h0, 16'h0, 1'h0, 1'h1);
        frm(16'h0800, FC_DA, 1'h0, 16'h0, 1'h0, 1'h1);
        frm(16'h0800, 48'h0, 1'h1, 16'h0, 1'h0, 1'h0);
        wr(ADDR_GC1, 8'h0C);
        frm(16'h0040, 48'h0, 1'h0, 16'h0041, 1'h0, 1'h1);
        frm(16'h0040, 48'h0, 1'h0, 16'h0040, 1'h0, 1'h0);
        frm(LEN_FIELD_MAX, 48'h0, 1'h0, 16'h0041, 1'h0, 1'h0);
        wr(ADDR_GC1, 8'h8C);
        frm(16'h0040, 48'h0, 1'h1, 16'h0041, 1'h1, 1'h0);
        wr(ADDR_GC1, 8'h01);
        `CHK("aggr_backoff", 1'h1, aggr_backoff)
    endtask
    task automatic t_age();
        n = 0;
        repeat (1500) begin @(posedge ref_clk); if (age_pass === 1'h1) n++; end
        `CHK("pass_count", 0, n)
        wr(ADDR_GC1, 8'h06);
        gap(n);
        gap(n);
        `CHK("fast_gap", 1'h1, n >= FAST * US_CYC - 10 && n <= FAST * US_CYC + 10)
        wr(ADDR_GC1, 8'h04);
        wr(ADDR_GC0, 8'h4D);
        port_link <= 5'h1B;
        repeat (2) @(posedge ref_clk);
        `CHK("age_flush_all", 1'h1, age_flush_all)
        // link-triggered fast pass running, aging active
        rchk(ADDR_STAT, 32'h3);
        gap(n);
        `CHK("link_gap", 1'h1, n >= FAST * US_CYC - 60 && n <= FAST * US_CYC + 10)
        gap(n);
        `CHK("normal_gap", 1'h1, n >= NORM * US_CYC - 10 && n <= NORM * US_CYC + 10)
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'h1;
        t_reset();
        t_flow();
        t_frame();
        t_age();
        complete_run();
    end
endmodule
bind sgc_top sgc_top_monitor mon_u (.ref_clk(ref_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .port_link(port_link), .an_pause_tx(an_pause_tx), .an_pause_rx(an_pause_rx),
    .frm_valid(frm_valid), .frm_done(frm_done), .port_buf_cap(port_buf_cap), .pause_tx_en(pause_tx_en),
    .pause_rx_en(pause_rx_en), .age_pass(age_pass), .age_flush_all(age_flush_all));
`default_nettype wire
